// ### spic_pkg.sv
package spic_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned REF_CLK_HZ     = 250_000_000;
	localparam int unsigned MASTER_HALF_NS = 16;
	localparam int unsigned MASTER_HALF_CYC =
		(MASTER_HALF_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned BYTE_BITS      = 8;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic rx_full_irq_en;
		logic master_select;
		logic clock_phase_sel;
		logic wired_or_pins;
		logic port_enable;
		logic tx_empty_irq_en;
		logic error_irq_en;
		logic fault_detect_en;
	} spic_ctrl_t;

	typedef struct packed {
		logic rx_full_flag;
		logic overrun_flag;
		logic select_fault_flag;
		logic tx_empty_flag;
	} spic_flags_t;

	typedef struct packed {
		logic mosi_o;
		logic mosi_oe_n;
		logic sclk_o;
		logic sclk_oe_n;
		logic miso_oe_n;
	} spic_pins_t;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam spic_ctrl_t  CTRL_RST  = 8'h60;
	localparam spic_flags_t FLAGS_RST = 4'h1;
	localparam spic_pins_t  PINS_IDLE = 5'h0b;

endpackage

// ### spic_port.sv
`timescale 1ns/100ps
// Contract
// (RL1) Transmit request needs tx empty, its enable, port enabled, DMA select low.
// (RL2) Receive request needs rx full and its enable, DMA low, any port enable.
// (RL3) Error enable lets overrun and select fault drive the receive/error request.
// (RL4) Rx full clears by status read while set, then data read.
// (RL5) Tx empty clears only by a data write.
// (RL6) Byte into receive buffer sets rx full; buffer into shifter sets tx empty.
// (RL7) System reset returns everything to its initial state.
// (RL8) Port disabled: tx empty set, transfer aborted, shifter cleared, pins released.
// (RL9) Control bits and rx, overrun, fault flags survive disabling.
// (RL10) Master select fault clears the port enable.
// (RL11) Wait mode: port runs, CPU access ignored, enabled requests wake.
// (RL12) Stop mode halts with contents kept; reset aborts and resets.
// (RL13) Break without permission: software cannot change flags; second steps wait.
// (RL14) Break with permission: software clears act and stay cleared.
// (RL15) Break without permission: data writes have no effect.
// (RL16) Slave data-out driven only as slave with select low.
// (RL17) Enabled port owns direction of data and clock pins.
// (RL18) Master drives clock, slave takes it; eight clocks move one byte.
// (RL19) Peer toggles select between bytes in phase 0; may hold in phase 1.
// (RL20) Deselected slave ignores all clock edges, even mid-byte.
// (RL21) Select pin ownership follows enable, master select and fault detection.
// (RL22) Wired-OR makes data-out pins open-drain; the code applies it to MOSI as master only, slave MISO stays push-pull.
// (RL23) Fault: select high in slave transfer, or select low as master.
// (RL24) Overrun clears by status then data read; bytes meanwhile dropped.
// (RL25) Requests are levels that drop when their flag clears.
module spic_port
	import spic_pkg::*;
#(
	parameter int unsigned HALF_CYC = MASTER_HALF_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic        CE,
	input  wire logic        LINK_CLK,
	input  wire logic        WAIT_MODE,
	input  wire logic        STOP_MODE,
	input  wire logic        BREAK_ACTIVE,
	input  wire logic        BREAK_CLEAR_PERMIT,
	input  wire logic        DMA_SELECT,
	input  wire logic        CTRL_WR,
	input  wire spic_ctrl_t  CTRL_WDATA,
	input  wire logic        STAT_RD,
	input  wire logic        DATA_RD,
	input  wire logic        DATA_WR,
	input  wire logic [7:0]  DATA_WDATA,
	input  wire logic        SS_N,
	input  wire logic        MOSI_I,
	input  wire logic        MISO_I,
	output spic_ctrl_t       CTRL_Q,
	output spic_flags_t      FLAGS_Q,
	output logic [7:0]       RX_DATA,
	output logic             TX_IRQ,
	output logic             RX_IRQ,
	output logic             WAKE_REQ,
	output logic             PINS_OWNED,
	output logic             SS_OWNED,
	output logic             MOSI_O,
	output logic             MOSI_OE_N,
	output logic             SCLK_O,
	output logic             SCLK_OE_N,
	output logic             MISO_O,
	output logic             MISO_OE_N
);

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef struct packed {
		spic_ctrl_t  ctrl;
		spic_flags_t flags;
		spic_pins_t  pins;
		logic [7:0]  tx_buf;
		logic [7:0]  rx_buf;
		logic [7:0]  sh;
		logic [3:0]  bitn;
		logic [7:0]  div;
		logic        sclk;
		logic        mbusy;
		logic        arm_rx;
		logic        arm_ovr;
		logic        arm_flt;
		logic [2:0]  ss_s;
		logic [2:0]  miso_s;
		logic [2:0]  busy_s;
		logic [2:0]  done_s;
		logic [2:0]  ack_s;
		logic        ss_f;
		logic        miso_f;
		logic        busy_f;
		logic        slave_act;
	} spic_ref_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic [7:0] sh;
	} spic_lsh_t;

	typedef struct packed {
		logic [7:0] rxw;
		logic       done_t;
		logic       ack_t;
	} spic_ltg_t;

	localparam spic_ref_t REF_RST = '{
		ctrl: CTRL_RST, flags: FLAGS_RST, pins: PINS_IDLE,
		ss_s: 3'h7, ss_f: 1'b1, default: '0};

	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
	localparam logic [3:0] LAST_BIT  = 4'(BYTE_BITS - 1);

	spic_ref_t r_reg;
	spic_ref_t r_next;
	spic_lsh_t lsh_reg;
	spic_lsh_t lsh_next;
	spic_ltg_t ltg_reg;
	spic_ltg_t ltg_next;

	logic       link_hold;
	logic       link_idle;
	logic       cpu_ok;
	logic       frozen;
	logic       ss_new;
	logic       ss_rise;
	logic       done_ev;
	logic       ack_ev;
	logic       mfault;
	logic       byte_done;
	logic [7:0] byte_val;

	// ------------------------------------------------------------
	// Reference clock domain
	// ------------------------------------------------------------

	// Access gating: wait mode locks the CPU out, break may lock flags
	assign cpu_ok = !WAIT_MODE; // RL11
	assign frozen = BREAK_ACTIVE && !BREAK_CLEAR_PERMIT; // RL13

	// Pin filters: a new level counts once two stages agree
	assign ss_new  = (r_reg.ss_s[1] == r_reg.ss_s[2]) ? r_reg.ss_s[2] : r_reg.ss_f;
	assign ss_rise = !r_reg.ss_f && ss_new;
	assign done_ev = r_reg.done_s[1] ^ r_reg.done_s[2];
	assign ack_ev  = r_reg.ack_s[1] ^ r_reg.ack_s[2];

	// Select fault in either role, only with detection on
	always_comb begin
		mfault = 1'b0;
		if (r_reg.ctrl.port_enable && r_reg.ctrl.fault_detect_en) begin
			if (r_reg.ctrl.master_select)
				mfault = !ss_new; // RL23
			else
				mfault = ss_rise && (!r_reg.ctrl.clock_phase_sel || r_reg.busy_f); // RL23
		end
	end

	// Next state of the register side and the master engine
	always_comb begin
		r_next    = r_reg;
		byte_done = 1'b0;
		byte_val  = ltg_reg.rxw;

		r_next.ss_s   = {r_reg.ss_s[1:0], SS_N};
		r_next.miso_s = {r_reg.miso_s[1:0], MISO_I};
		r_next.busy_s = {r_reg.busy_s[1:0], !link_idle};
		r_next.ss_f   = ss_new;
		if (r_reg.miso_s[1] == r_reg.miso_s[2]) begin
			r_next.miso_f = r_reg.miso_s[2];
		end
		if (r_reg.busy_s[1] == r_reg.busy_s[2]) begin
			r_next.busy_f = r_reg.busy_s[2];
		end
		// Toggles restart from zero whenever the link side is held
		if (r_reg.slave_act) begin
			r_next.done_s = {r_reg.done_s[1:0], ltg_reg.done_t};
			r_next.ack_s  = {r_reg.ack_s[1:0], ltg_reg.ack_t};
		end else begin
			r_next.done_s = '0;
			r_next.ack_s  = '0;
		end

		// Control write; control bits stay when the port is off
		if (CTRL_WR && cpu_ok) begin
			r_next.ctrl = CTRL_WDATA; // RL9
			if (r_reg.arm_flt && !mfault && !frozen) begin
				r_next.flags.select_fault_flag = 1'b0; // RL13 RL14
			end
			r_next.arm_flt = 1'b0;
		end

		// Status read arms the two-step clears
		if (STAT_RD && cpu_ok && !frozen) begin
			r_next.arm_rx  = r_reg.flags.rx_full_flag;
			r_next.arm_ovr = r_reg.flags.overrun_flag;
			r_next.arm_flt = r_reg.flags.select_fault_flag;
		end

		// Data read completes the rx full and overrun clears armed before
		if (DATA_RD && cpu_ok && !frozen) begin
			if (r_reg.arm_rx) begin
				r_next.flags.rx_full_flag = 1'b0; // RL4
			end
			if (r_reg.arm_ovr) begin
				r_next.flags.overrun_flag = 1'b0; // RL24
			end
			r_next.arm_rx  = 1'b0;
			r_next.arm_ovr = 1'b0;
		end

		// Data write fills the transmit buffer; dropped while frozen
		if (DATA_WR && cpu_ok && !frozen) begin // RL15
			r_next.tx_buf              = DATA_WDATA;
			r_next.flags.tx_empty_flag = 1'b0; // RL5
		end

		// Master engine: load, then two half periods per bit
		if (r_reg.ctrl.port_enable && r_reg.ctrl.master_select) begin
			if (!r_reg.mbusy) begin
				if (!r_reg.flags.tx_empty_flag) begin
					r_next.sh                  = r_reg.tx_buf;
					r_next.flags.tx_empty_flag = 1'b1; // RL6
					r_next.mbusy               = 1'b1;
					r_next.bitn                = '0;
					r_next.div                 = '0;
				end
			end else if (r_reg.div == HALF_LAST) begin
				r_next.div = '0;
				if (!r_reg.sclk) begin
					// Filter lags four cycles: sample at the fall; HALF_CYC 3 or more
					r_next.sclk = 1'b1;
				end else begin
					r_next.sclk = 1'b0;
					r_next.sh   = {r_reg.sh[6:0], r_reg.miso_f};
					r_next.bitn = r_reg.bitn + 4'h1;
					if (r_reg.bitn == LAST_BIT) begin // RL18
						r_next.mbusy = 1'b0;
						byte_done    = 1'b1;
						byte_val     = {r_reg.sh[6:0], r_reg.miso_f};
					end
				end
			end else begin
				r_next.div = r_reg.div + 8'h01;
			end
		end

		// Slave side events from the link domain
		if (r_reg.slave_act && done_ev) begin
			byte_done = 1'b1;
		end
		if (r_reg.slave_act && ack_ev) begin
			r_next.flags.tx_empty_flag = 1'b1; // RL6
		end

		// Received byte: a full buffer or pending overrun drops it
		if (byte_done) begin
			if (r_reg.flags.rx_full_flag || r_reg.flags.overrun_flag) begin
				r_next.flags.overrun_flag = 1'b1; // RL24
			end else begin
				r_next.rx_buf             = byte_val;
				r_next.flags.rx_full_flag = 1'b1; // RL6
			end
		end

		// Fault as master drops the port enable like a software write
		if (mfault) begin
			r_next.flags.select_fault_flag = 1'b1; // RL23
			if (r_reg.ctrl.master_select) begin
				r_next.ctrl.port_enable = 1'b0; // RL10
			end
		end

		// Partial reset while disabled; flags other than tx empty kept
		if (!r_next.ctrl.port_enable) begin
			r_next.flags.tx_empty_flag = 1'b1; // RL8
			r_next.sh    = '0;
			r_next.bitn  = '0;
			r_next.div   = '0;
			r_next.sclk  = 1'b0;
			r_next.mbusy = 1'b0;
		end
		r_next.slave_act = r_next.ctrl.port_enable && !r_next.ctrl.master_select;

		// Pin direction: enabled port overrides the port direction
		r_next.pins = PINS_IDLE; // RL8
		if (r_next.ctrl.port_enable) begin
			if (r_next.ctrl.master_select) begin
				r_next.pins.sclk_o    = r_next.sclk;
				r_next.pins.sclk_oe_n = 1'b0; // RL17 RL18
				r_next.pins.mosi_o    = r_next.sh[7] && !r_next.ctrl.wired_or_pins;
				// Open drain only pulls low; pull-up makes the one
				r_next.pins.mosi_oe_n = r_next.ctrl.wired_or_pins && r_next.sh[7]; // RL22
			end else begin
				r_next.pins.miso_oe_n = ss_new; // RL16 RL17
			end
		end
	end

	// Register update; stop mode and clock enable both freeze it
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			r_reg <= REF_RST; // RL7
		end else if (CE && !STOP_MODE) begin // RL12
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// Link clock domain (slave shifting)
	// ------------------------------------------------------------

	// Held while not an enabled slave; counter also while deselected
	assign link_hold = !r_reg.slave_act;
	assign link_idle = (lsh_reg.cnt == 3'h0);

	// The transmit buffer is stable here: software writes only when empty
	always_comb begin
		lsh_next = lsh_reg;
		ltg_next = ltg_reg;
		if (link_idle) begin
			lsh_next.sh    = {r_reg.tx_buf[6:0], MOSI_I};
			ltg_next.ack_t = !ltg_reg.ack_t;
		end else begin
			lsh_next.sh = {lsh_reg.sh[6:0], MOSI_I};
		end
		if (lsh_reg.cnt == 3'h7) begin
			ltg_next.rxw    = {lsh_reg.sh[6:0], MOSI_I};
			ltg_next.done_t = !ltg_reg.done_t;
		end
		lsh_next.cnt = lsh_reg.cnt + 3'h1; // RL18
	end

	// Select high clears the bit counter, so stray edges do nothing
	always_ff @(posedge LINK_CLK or posedge link_hold or posedge SS_N) begin
		if (link_hold || SS_N) begin
			lsh_reg <= '0; // RL20 RL8
		end else begin
			lsh_reg <= lsh_next;
		end
	end

	// Toggles reset only with the port, so a deselect adds no event
	always_ff @(posedge LINK_CLK or posedge link_hold) begin
		if (link_hold) begin
			ltg_reg <= '0;
		end else if (!SS_N) begin
			ltg_reg <= ltg_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign CTRL_Q     = r_reg.ctrl;
	assign FLAGS_Q    = r_reg.flags;
	assign RX_DATA    = r_reg.rx_buf;
	assign PINS_OWNED = r_reg.ctrl.port_enable; // RL17
	// Select is ours as slave, or as master with detection
	assign SS_OWNED   = r_reg.ctrl.port_enable &&
		(!r_reg.ctrl.master_select || r_reg.ctrl.fault_detect_en); // RL21
	assign MOSI_O     = r_reg.pins.mosi_o;
	assign MOSI_OE_N  = r_reg.pins.mosi_oe_n;
	assign SCLK_O     = r_reg.pins.sclk_o;
	assign SCLK_OE_N  = r_reg.pins.sclk_oe_n;
	assign MISO_OE_N  = r_reg.pins.miso_oe_n;
	// First bit comes straight from the buffer before any edge
	assign MISO_O     = link_idle ? r_reg.tx_buf[7] : lsh_reg.sh[7];

	// Request levels follow their flags and enables
	assign TX_IRQ   = !DMA_SELECT && r_reg.ctrl.tx_empty_irq_en &&
		r_reg.ctrl.port_enable && r_reg.flags.tx_empty_flag; // RL1 RL25
	assign RX_IRQ   = (!DMA_SELECT && r_reg.ctrl.rx_full_irq_en &&
		r_reg.flags.rx_full_flag) || // RL2
		(r_reg.ctrl.error_irq_en &&
		(r_reg.flags.overrun_flag || r_reg.flags.select_fault_flag)); // RL3 RL25
	assign WAKE_REQ = WAIT_MODE && (TX_IRQ || RX_IRQ); // RL11

endmodule

// ### spic_port_chk.sv
`timescale 1ns/100ps
module spic_port_chk
	import spic_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        RESET,
	input wire logic        DMA_SELECT,
	input wire logic        DATA_WR,
	input wire logic        DATA_RD,
	input wire logic        WAIT_MODE,
	input wire logic        SS_N,
	input wire spic_ctrl_t  CTRL_Q,
	input wire spic_flags_t FLAGS_Q,
	input wire logic        TX_IRQ,
	input wire logic        RX_IRQ,
	input wire logic        WAKE_REQ,
	input wire logic        PINS_OWNED,
	input wire logic        SS_OWNED,
	input wire logic        MOSI_O,
	input wire logic        MOSI_OE_N,
	input wire logic        SCLK_OE_N,
	input wire logic        MISO_OE_N
);
	// ------------------------------------------------------------
	// Request levels and ownership
	// ------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	tx_req_a: assert property (
		TX_IRQ == (!DMA_SELECT && CTRL_Q.port_enable && CTRL_Q.tx_empty_irq_en
			&& FLAGS_Q.tx_empty_flag)) else $error("tx request wrong");
	rx_req_a: assert property (
		RX_IRQ == ((!DMA_SELECT && CTRL_Q.rx_full_irq_en && FLAGS_Q.rx_full_flag)
			|| (CTRL_Q.error_irq_en && (FLAGS_Q.overrun_flag
			|| FLAGS_Q.select_fault_flag)))) else $error("rx request wrong");
	wake_req_a: assert property (WAIT_MODE |-> WAKE_REQ == (TX_IRQ || RX_IRQ))
		else $error("wake request wrong");
	select_own_a: assert property (
		SS_OWNED == (CTRL_Q.port_enable && (!CTRL_Q.master_select
			|| CTRL_Q.fault_detect_en))) else $error("select ownership wrong");
	// Registered pin enables update in the same cycle as the control
	off_state_a: assert property (!CTRL_Q.port_enable [*2] |->
		MOSI_OE_N && SCLK_OE_N && MISO_OE_N && !PINS_OWNED
		&& FLAGS_Q.tx_empty_flag) else $error("disabled port not idle");
	miso_release_a: assert property (SS_N [*5] |=> MISO_OE_N)
		else $error("slave output driven while deselected");
	open_drain_a: assert property (
		CTRL_Q.wired_or_pins && CTRL_Q.master_select && !MOSI_OE_N |-> !MOSI_O)
		else $error("open drain drives high");
	// ------------------------------------------------------------
	// Flag causes
	// ------------------------------------------------------------
	tx_clear_a: assert property (
		$fell(FLAGS_Q.tx_empty_flag) |-> $past(DATA_WR) || $past(RESET))
		else $error("tx empty cleared without write");
	rx_clear_a: assert property (
		$fell(FLAGS_Q.rx_full_flag) |-> $past(DATA_RD) || $past(RESET))
		else $error("rx full cleared without data read");
	fault_set_a: assert property (
		$rose(FLAGS_Q.select_fault_flag) |-> $past(CTRL_Q.fault_detect_en))
		else $error("fault set while detection off");
	fault_off_a: assert property (
		$rose(FLAGS_Q.select_fault_flag) && $past(CTRL_Q.master_select)
		|-> ##[0:1] !CTRL_Q.port_enable) else $error("master fault kept enable");
	reset_val_a: assert property (disable iff (1'b0)
		RESET |=> CTRL_Q == CTRL_RST && FLAGS_Q == FLAGS_RST) else $error("reset state");
endmodule
bind spic_port spic_port_chk chk (.REF_CLK, .RESET, .DMA_SELECT, .DATA_WR, .DATA_RD,
	.WAIT_MODE, .SS_N, .CTRL_Q, .FLAGS_Q, .TX_IRQ, .RX_IRQ, .WAKE_REQ, .PINS_OWNED,
	.SS_OWNED, .MOSI_O, .MOSI_OE_N, .SCLK_OE_N, .MISO_OE_N);

// ### spic_peer.sv
`timescale 1ns/100ps
module spic_peer (
	output logic      link_clk,
	output logic      ss_n,
	output logic      mosi_i,
	output logic      miso_i,
	input  wire logic sclk_w,
	input  wire logic mosi_w,
	input  wire logic miso_w
);
	logic [7:0] sl_tx;
	logic [7:0] sl_rx;
	// Idle: clock parked low, not selected
	initial begin
		link_clk = 1'b0;
		ss_n = 1'b1;
		mosi_i = 1'b0;
	end
	// Slave answer for a device master, MSB first
	assign miso_i = sl_tx[7];
	always @(posedge sclk_w) begin
		sl_rx <= {sl_rx[6:0], mosi_w};
	end
	always @(negedge sclk_w) begin
		sl_tx <= {sl_tx[6:0], ~sl_tx[0]};
	end
	// Master frame at 64 ns; clock only runs inside the frame
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#13;
		ss_n = 1'b0;
		#64;
		for (int i = 7; i >= 0; i--) begin
			mosi_i = tx[i];
			#32;
			rx[i] = miso_w;
			link_clk = 1'b1;
			#32;
			link_clk = 1'b0;
		end
		#64;
		ss_n = 1'b1;
		mosi_i = ~mosi_i;
	endtask
endmodule

// ### spic_port_bench.sv
`timescale 1ns/100ps
module spic_port_bench
	import spic_pkg::*;
;
	logic        ref_clk, reset, wait_mode, brk, permit, dma, stop;
	logic        ctrl_wr, stat_rd, data_rd, data_wr;
	logic [7:0]  wdata, got, rx_data;
	spic_ctrl_t  ctrl_q;
	spic_flags_t flags_q;
	logic        tx_irq, rx_irq, wake, pins_own, ss_own;
	logic        mosi_o, mosi_oe_n, sclk_o, sclk_oe_n, miso_o, miso_oe_n;
	wire         link_clk, ss_n, mosi_i, miso_i;
	int          error_cnt = 0;
	int          samples_checked = 0;
	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;
	spic_port dut (.REF_CLK(ref_clk), .RESET(reset), .CE(1'b1), .LINK_CLK(link_clk),
		.WAIT_MODE(wait_mode), .STOP_MODE(stop), .BREAK_ACTIVE(brk),
		.BREAK_CLEAR_PERMIT(permit), .DMA_SELECT(dma), .CTRL_WR(ctrl_wr),
		.CTRL_WDATA(spic_ctrl_t'(wdata)), .STAT_RD(stat_rd), .DATA_RD(data_rd),
		.DATA_WR(data_wr), .DATA_WDATA(wdata), .SS_N(ss_n), .MOSI_I(mosi_i),
		.MISO_I(miso_i), .CTRL_Q(ctrl_q), .FLAGS_Q(flags_q), .RX_DATA(rx_data),
		.TX_IRQ(tx_irq), .RX_IRQ(rx_irq), .WAKE_REQ(wake), .PINS_OWNED(pins_own),
		.SS_OWNED(ss_own), .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n), .SCLK_O(sclk_o),
		.SCLK_OE_N(sclk_oe_n), .MISO_O(miso_o), .MISO_OE_N(miso_oe_n));
	// Data-out has a pull-up; a released slave line shows a changed level
	spic_peer peer (.link_clk, .ss_n, .mosi_i, .miso_i, .sclk_w(sclk_o & ~sclk_oe_n),
		.mosi_w(mosi_oe_n | mosi_o), .miso_w(miso_oe_n ? ~miso_o : miso_o));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Strobe mask is {ctrl_wr, stat_rd, data_rd, data_wr}; one idle edge after
	task automatic op(input logic [3:0] m, input logic [7:0] d = 8'h00);
		{ctrl_wr, stat_rd, data_rd, data_wr} = m;
		wdata = d;
		tick();
		{ctrl_wr, stat_rd, data_rd, data_wr} = 4'h0;
		tick();
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wait_rx();
		for (int n = 0; n < 2000 && flags_q.rx_full_flag !== 1'b1; n++) begin
			tick();
		end
		if (flags_q.rx_full_flag !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH t=%0t receive timeout", $time);
		end
		tick();
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Whole sequence needs well under 10 us
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{reset, wait_mode, brk, permit, dma, stop} = 6'h20;
		{ctrl_wr, stat_rd, data_rd, data_wr} = 4'h0;
		wdata = 8'h00;
		tick(2);
		reset = 1'b0;
		// Loaded after reset: the clock pin leaving unknown is a falling edge
		peer.sl_tx = 8'h3c;
		chk(ctrl_q, CTRL_RST);
		chk(flags_q, FLAGS_RST);
		chk({mosi_oe_n, sclk_oe_n, miso_oe_n}, 8'h07);
		// Master, open-drain data-out; a break write must start nothing
		op(4'h8, 8'h7c);
		chk(tx_irq, 1'b1);
		brk = 1'b1;
		op(4'h1, 8'h11);
		tick(100);
		chk(flags_q.rx_full_flag, 1'b0);
		brk = 1'b0;
		// Empty flag is low for one cycle before the master loads
		{data_wr, wdata} = 9'h1a5;
		tick();
		data_wr = 1'b0;
		chk(flags_q.tx_empty_flag, 1'b0);
		tick();
		wait_rx();
		chk(rx_data, 8'h3c);
		chk(peer.sl_rx, 8'ha5);
		chk(flags_q.tx_empty_flag, 1'b1);
		chk(rx_irq, 1'b0);
		$display("test master done");
		// Disable keeps flags and control; rx request stays live
		op(4'h8, 8'he4);
		chk(ctrl_q, 8'he4);
		chk(flags_q, 8'h09);
		chk({rx_irq, tx_irq, pins_own}, 8'h04);
		dma = 1'b1;
		tick();
		chk(rx_irq, 1'b0);
		dma = 1'b0;
		wait_mode = 1'b1;
		op(4'h4);
		op(4'h2);
		chk({flags_q.rx_full_flag, wake}, 8'h03);
		wait_mode = 1'b0;
		brk = 1'b1;
		op(4'h4);
		op(4'h2);
		chk(flags_q.rx_full_flag, 1'b1);
		permit = 1'b1;
		op(4'h4);
		op(4'h2);
		{brk, permit} = 2'b00;
		tick();
		chk(flags_q.rx_full_flag, 1'b0);
		$display("test retain done");
		// Select low on a fault-checking master
		op(4'h8, 8'h6b);
		peer.ss_n = 1'b0;
		tick(8);
		chk(flags_q.select_fault_flag, 1'b1);
		chk({ctrl_q.port_enable, rx_irq}, 8'h01);
		peer.ss_n = 1'b1;
		tick(8);
		op(4'h4);
		op(4'h8, 8'h6a);
		chk(flags_q.select_fault_flag, 1'b0);
		$display("test fault done");
		// Slave exchange clocked by the peer
		op(4'h8, 8'h28);
		tick(6);
		chk({miso_oe_n, ss_own}, 8'h03);
		op(4'h1, 8'h96);
		chk(flags_q.tx_empty_flag, 1'b0);
		peer.xfer(8'h5a, got);
		wait_rx();
		chk(rx_data, 8'h5a);
		chk(got, 8'h96);
		// Second byte into a full buffer is dropped
		peer.xfer(8'hc3, got);
		wait_rx();
		chk(flags_q, 8'h0d);
		chk(rx_data, 8'h5a);
		op(4'h4);
		op(4'h2);
		chk(flags_q, 8'h01);
		$display("test slave done");
		// Stop freezes the port; a reset out of stop restores it
		stop = 1'b1;
		op(4'h8, 8'h00);
		chk(ctrl_q, 8'h28);
		reset = 1'b1;
		tick(2);
		{reset, stop} = 2'b00;
		chk(ctrl_q, CTRL_RST);
		chk(flags_q, FLAGS_RST);
		$display("test stop done");
		end_of_test();
	end
endmodule
